// >>> shared/ppmc_defines.vh
`ifndef PPMC_DEFINES_VH
`define PPMC_DEFINES_VH
// register byte addresses (word aligned)
`define PPMC_ADDR_MODE 8'h00
`define PPMC_ADDR_SETTINGS 8'h04
`define PPMC_ADDR_CTRL 8'h08
`define PPMC_ADDR_STATUS 8'h0C
`define PPMC_ADDR_IRQ_STAT 8'h10
`define PPMC_ADDR_IRQ_MASK 8'h14
`define PPMC_ADDR_CHG 8'h18
`define PPMC_ADDR_DEFAULTS 8'h1C
// mode field encodings
`define PPMC_MODE_OFF 4'h0
`define PPMC_MODE_NOCHG 4'h4
`define PPMC_MODE_CHG 4'h5
`define PPMC_MODE_REV 4'hA
`define PPMC_MODE_RST 4'h5
// charger sub-state codes from the charger state machine
`define PPMC_CS_PRE 3'h0
`define PPMC_CS_TRICKLE 3'h1
`define PPMC_CS_FAST 3'h2
`define PPMC_CS_TOPOFF 3'h3
`define PPMC_CS_DONE 3'h4
`define PPMC_CS_THERM 3'h5
`define PPMC_CS_WDOG 3'h6
`define PPMC_CS_TFAULT 3'h7
// charger detail code while held off by strap
`define PPMC_DTLS_HELD 8'h05
// reset values of host settings; maximum reverse current limit field
`define PPMC_VINREG_RST 5'h00
`define PPMC_RILIM_RST 3'h0
`define PPMC_RILIM_MAX 3'h7
// control bit positions
`define PPMC_CTRL_STANDBY 0
`define PPMC_CTRL_HCE 1
// input status / irq bit positions
`define PPMC_IRQ_INCHG 0
// power path target encodings
`define PPMC_SW_OFF 2'h0
`define PPMC_SW_ON 2'h1
`define PPMC_SW_LINEAR 2'h2
`define PPMC_SW_SUPPL 2'h3
`define PPMC_SYS_NONE 2'h0
`define PPMC_SYS_BATTREG 2'h1
`define PPMC_SYS_SUPPL 2'h2
// input detail codes
`define PPMC_IN_UV 2'h0
`define PPMC_IN_OV 2'h2
`define PPMC_IN_OK 2'h3
// power states
`define PPMC_PS_BATT 3'h1
`define PPMC_PS_NOCHG 3'h2
`define PPMC_PS_CHG 3'h3
`define PPMC_PS_REV 3'h4
`define PPMC_PS_STANDBY 3'h5
`endif

// >>> verilog/ppmc_sync2.v
// two-stage synchroniser, one per bit
module ppmc_sync2 #(
    parameter W = 2
) (
    input wire i_ref_clk,
    input wire i_arst_n,
    input wire [W-1:0] i_d,
    output wire [W-1:0] o_q
);
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1)
        begin : g_bit
            reg meta_ff;
            reg sync_ff;
            always @(posedge i_ref_clk or negedge i_arst_n)
            begin
                if (!i_arst_n)
                begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                end
                else
                begin
                    meta_ff <= i_d[g];
                    sync_ff <= meta_ff;
                end
            end
            assign o_q[g] = sync_ff;
        end
    endgenerate
endmodule

// >>> verilog/ppmc_power_path.v
// Functional notes
// - valid input with mode 0, standby bit or standby pin: converter off, switch on.
// - valid input, mode 4: converter on, no charging, system at battery regulation, switch off.
// - mode 5 non-charging sub-states: system at battery regulation, switch off.
// - mode 5 precharge or trickle: system at battery regulation, switch linear.
// - mode 5 fast charge or top-off: switch fully on.
// - switch off and system sagging to supplement level: switch to supplement, regulate there.
// - no valid input, reverse mode included: switch fully on regardless of mode.
// - reverse mode regulates input to 5.1V, 3-bit current limit, 3A maximum.
// - forward mode regulates input to 5-bit input regulation setting.
// - invalid or out-of-range input: battery-only state in any mode except reverse outside standby, which gives the reverse state.
// - mode field resets to 0x05, charging forward.
// - strap mix of resistor and bias-tied pins: hold charging, detail 0x05, good cleared.
// - host charge enable resets to 0; charging held until host sets it.
// - four defaults from straps; host may overwrite each over the bus.
// - undervoltage qualification latches; clears only in loop with input current under 30mA.
// - input valid only when qualified above undervoltage and below overvoltage.
// - input status change raises interrupt; mask bit suppresses the output.
// - readable input valid flag and 2-bit input detail field.
`include "ppmc_defines.vh"
module ppmc_power_path (
    input wire i_ref_clk,
    input wire i_arst_n,
    input wire [7:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output reg [31:0] o_avs_readdata,
    output reg o_avs_waitrequest,
    output reg [1:0] o_avs_response,
    input wire i_standby_pin_input,
    input wire i_uvlo_above,
    input wire i_ovlo_below,
    input wire i_adaptive_input_current_loop,
    input wire i_iin_below_30ma,
    input wire i_sys_at_supplement,
    input wire [2:0] i_chg_substate,
    input wire [3:0] i_cfg_pin_resistor,
    input wire [3:0] i_cfg_pin_bias,
    input wire [7:0] i_charger_detail_sm,
    input wire i_chg_good_sm,
    input wire [6:0] i_dflt_input_limit,
    input wire [5:0] i_dflt_topoff,
    input wire [6:0] i_dflt_charge_current,
    input wire [5:0] i_dflt_term_voltage,
    output reg o_converter_en,
    output reg o_charge_en,
    output reg o_reverse_en,
    output reg [1:0] o_battery_path_switch,
    output reg [1:0] o_sys_target,
    output reg [4:0] o_vin_reg_target,
    output reg o_vin_reg_fixed_5v1,
    output reg [2:0] o_rev_ilim,
    output reg [2:0] o_power_state,
    output reg [6:0] o_input_limit,
    output reg [5:0] o_topoff,
    output reg [6:0] o_charge_current,
    output reg [5:0] o_term_voltage,
    output reg o_irq
);
    wire [1:0] cmp_sync;
    reg [3:0] mode_ff;
    reg standby_request_bit_ff;
    reg host_charge_enable_ff;
    reg [4:0] input_regulation_voltage_setting_ff;
    reg [2:0] reverse_current_limit_field_ff;
    reg [6:0] lim_ff;
    reg [5:0] topoff_ff;
    reg [6:0] chg_cur_ff;
    reg [5:0] term_v_ff;
    reg strap_done_ff;
    reg strap_hold_ff;
    reg uv_qual_ff;
    reg [1:0] input_detail_field_ff;
    reg input_change_interrupt_ff;
    reg input_change_mask_ff;
    reg [31:0] nxt_rdata;
    reg nxt_err;
    reg [1:0] nxt_sw;
    reg [1:0] nxt_sys;
    reg [2:0] nxt_ps;
    reg nxt_conv;
    reg nxt_chg;
    reg nxt_rev;
    wire input_valid_flag;
    wire [1:0] nxt_detail;
    wire bus_req;
    wire wr_hit;
    wire standby_any;
    wire chg_noncharging;
    wire chg_linear;
    wire [7:0] charger_detail_code;
    wire charger_good_flag;

    ppmc_sync2 #(
        .W(2)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_d({i_ovlo_below, i_uvlo_above}),
        .o_q(cmp_sync)
    );

    // undervoltage qualifier latch
    always @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            uv_qual_ff <= 1'b0;
        else if (cmp_sync[0])
            uv_qual_ff <= 1'b1;
        else if (i_adaptive_input_current_loop && i_iin_below_30ma)
            uv_qual_ff <= 1'b0;
    end

    assign input_valid_flag = uv_qual_ff && cmp_sync[1];
    assign nxt_detail = !uv_qual_ff ? `PPMC_IN_UV :
                        !cmp_sync[1] ? `PPMC_IN_OV : `PPMC_IN_OK;

    // strap check captured once after reset release
    always @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            strap_done_ff <= 1'b0;
            strap_hold_ff <= 1'b0;
        end
        else if (!strap_done_ff)
        begin
            strap_done_ff <= 1'b1;
            strap_hold_ff <= (|i_cfg_pin_resistor) && (|i_cfg_pin_bias);
        end
    end

    assign charger_detail_code = strap_hold_ff ? `PPMC_DTLS_HELD : i_charger_detail_sm;
    assign charger_good_flag = strap_hold_ff ? 1'b0 : i_chg_good_sm;

    assign bus_req = i_avs_read || i_avs_write;
    assign wr_hit = i_avs_write && !o_avs_waitrequest;

    // register writes; charge settings load from straps until overwritten
    always @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            mode_ff <= `PPMC_MODE_RST;
            standby_request_bit_ff <= 1'b0;
            host_charge_enable_ff <= 1'b0;
            input_regulation_voltage_setting_ff <= `PPMC_VINREG_RST;
            reverse_current_limit_field_ff <= `PPMC_RILIM_RST;
            input_change_mask_ff <= 1'b0;
            lim_ff <= 7'h00;
            topoff_ff <= 6'h00;
            chg_cur_ff <= 7'h00;
            term_v_ff <= 6'h00;
        end
        else
        begin
            if (!strap_done_ff)
            begin
                lim_ff <= i_dflt_input_limit;
                topoff_ff <= i_dflt_topoff;
                chg_cur_ff <= i_dflt_charge_current;
                term_v_ff <= i_dflt_term_voltage;
            end
            else if (wr_hit && i_avs_address == `PPMC_ADDR_DEFAULTS)
            begin
                if (i_avs_byteenable[0])
                    lim_ff <= i_avs_writedata[6:0];
                if (i_avs_byteenable[1])
                    topoff_ff <= i_avs_writedata[13:8];
                if (i_avs_byteenable[2])
                    chg_cur_ff <= i_avs_writedata[22:16];
                if (i_avs_byteenable[3])
                    term_v_ff <= i_avs_writedata[29:24];
            end
            if (wr_hit && i_avs_byteenable[0])
            begin
                case (i_avs_address)
                    `PPMC_ADDR_MODE:
                        mode_ff <= i_avs_writedata[3:0];
                    `PPMC_ADDR_SETTINGS:
                        input_regulation_voltage_setting_ff <= i_avs_writedata[4:0];
                    `PPMC_ADDR_CTRL:
                    begin
                        standby_request_bit_ff <= i_avs_writedata[`PPMC_CTRL_STANDBY];
                        host_charge_enable_ff <= i_avs_writedata[`PPMC_CTRL_HCE];
                    end
                    `PPMC_ADDR_IRQ_MASK:
                        input_change_mask_ff <= i_avs_writedata[`PPMC_IRQ_INCHG];
                    default:
                        ;
                endcase
            end
            if (wr_hit && i_avs_byteenable[1] && i_avs_address == `PPMC_ADDR_SETTINGS)
                reverse_current_limit_field_ff <= i_avs_writedata[10:8];
        end
    end

    // input status and change interrupt; set wins over clear
    always @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            input_detail_field_ff <= `PPMC_IN_UV;
            input_change_interrupt_ff <= 1'b0;
        end
        else
        begin
            input_detail_field_ff <= nxt_detail;
            if (nxt_detail != input_detail_field_ff)
                input_change_interrupt_ff <= 1'b1;
            else if (wr_hit && i_avs_address == `PPMC_ADDR_IRQ_STAT &&
                     i_avs_byteenable[0] && i_avs_writedata[`PPMC_IRQ_INCHG])
                input_change_interrupt_ff <= 1'b0;
        end
    end

    assign standby_any = (mode_ff == `PPMC_MODE_OFF) || standby_request_bit_ff ||
                         i_standby_pin_input;
    assign chg_noncharging = i_chg_substate[2];
    assign chg_linear = (i_chg_substate == `PPMC_CS_PRE) ||
                        (i_chg_substate == `PPMC_CS_TRICKLE);

    // power path decision
    always @*
    begin
        nxt_sw = `PPMC_SW_ON;
        nxt_sys = `PPMC_SYS_NONE;
        nxt_ps = `PPMC_PS_BATT;
        nxt_conv = 1'b0;
        nxt_chg = 1'b0;
        nxt_rev = 1'b0;
        if (!input_valid_flag)
        begin
            nxt_sw = `PPMC_SW_ON;
            nxt_ps = `PPMC_PS_BATT;
            if (mode_ff == `PPMC_MODE_REV && !standby_any)
            begin
                nxt_rev = 1'b1;
                nxt_conv = 1'b1;
                nxt_ps = `PPMC_PS_REV;
            end
        end
        else if (standby_any)
        begin
            nxt_sw = `PPMC_SW_ON;
            nxt_ps = `PPMC_PS_STANDBY;
        end
        else if (mode_ff == `PPMC_MODE_NOCHG)
        begin
            nxt_conv = 1'b1;
            nxt_sys = `PPMC_SYS_BATTREG;
            nxt_sw = `PPMC_SW_OFF;
            nxt_ps = `PPMC_PS_NOCHG;
        end
        else if (mode_ff == `PPMC_MODE_CHG)
        begin
            nxt_conv = 1'b1;
            nxt_ps = `PPMC_PS_CHG;
            nxt_chg = host_charge_enable_ff && !strap_hold_ff && strap_done_ff;
            if (chg_noncharging || !nxt_chg)
            begin
                nxt_sys = `PPMC_SYS_BATTREG;
                nxt_sw = `PPMC_SW_OFF;
            end
            else if (chg_linear)
            begin
                nxt_sys = `PPMC_SYS_BATTREG;
                nxt_sw = `PPMC_SW_LINEAR;
            end
            else
                nxt_sw = `PPMC_SW_ON;
        end
        else
        begin
            nxt_sw = `PPMC_SW_ON;
            nxt_ps = `PPMC_PS_STANDBY;
        end
        if (nxt_conv && !nxt_rev && nxt_sw == `PPMC_SW_OFF && i_sys_at_supplement)
        begin
            nxt_sw = `PPMC_SW_SUPPL;
            nxt_sys = `PPMC_SYS_SUPPL;
        end
    end

    // registered outputs
    always @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_converter_en <= 1'b0;
            o_charge_en <= 1'b0;
            o_reverse_en <= 1'b0;
            o_battery_path_switch <= `PPMC_SW_ON;
            o_sys_target <= `PPMC_SYS_NONE;
            o_vin_reg_target <= `PPMC_VINREG_RST;
            o_vin_reg_fixed_5v1 <= 1'b0;
            o_rev_ilim <= `PPMC_RILIM_RST;
            o_power_state <= `PPMC_PS_BATT;
            o_input_limit <= 7'h00;
            o_topoff <= 6'h00;
            o_charge_current <= 7'h00;
            o_term_voltage <= 6'h00;
            o_irq <= 1'b0;
        end
        else
        begin
            o_converter_en <= nxt_conv;
            o_charge_en <= nxt_chg;
            o_reverse_en <= nxt_rev;
            o_battery_path_switch <= nxt_sw;
            o_sys_target <= nxt_sys;
            o_vin_reg_target <= input_regulation_voltage_setting_ff;
            o_vin_reg_fixed_5v1 <= nxt_rev;
            o_rev_ilim <= reverse_current_limit_field_ff;
            o_power_state <= nxt_ps;
            o_input_limit <= lim_ff;
            o_topoff <= topoff_ff;
            o_charge_current <= chg_cur_ff;
            o_term_voltage <= term_v_ff;
            o_irq <= input_change_interrupt_ff && !input_change_mask_ff;
        end
    end

    // read mux
    always @*
    begin
        nxt_rdata = 32'h00000000;
        nxt_err = 1'b0;
        case (i_avs_address)
            `PPMC_ADDR_MODE:
                nxt_rdata = {28'h0000000, mode_ff};
            `PPMC_ADDR_SETTINGS:
                nxt_rdata = {21'h000000, reverse_current_limit_field_ff,
                             3'h0, input_regulation_voltage_setting_ff};
            `PPMC_ADDR_CTRL:
                nxt_rdata = {30'h00000000, host_charge_enable_ff, standby_request_bit_ff};
            `PPMC_ADDR_STATUS:
                nxt_rdata = {21'h000000, o_power_state, 5'h00,
                             input_detail_field_ff, input_valid_flag};
            `PPMC_ADDR_IRQ_STAT:
                nxt_rdata = {31'h00000000, input_change_interrupt_ff};
            `PPMC_ADDR_IRQ_MASK:
                nxt_rdata = {31'h00000000, input_change_mask_ff};
            `PPMC_ADDR_CHG:
                nxt_rdata = {23'h000000, charger_good_flag, charger_detail_code};
            `PPMC_ADDR_DEFAULTS:
                nxt_rdata = {2'h0, term_v_ff, 1'b0, chg_cur_ff, 2'h0, topoff_ff, 1'b0, lim_ff};
            default:
                nxt_err = 1'b1;
        endcase
    end

    // one wait cycle per access: waitrequest low on the second cycle
    always @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h00000000;
            o_avs_response <= 2'h0;
        end
        else if (bus_req && o_avs_waitrequest)
        begin
            o_avs_waitrequest <= 1'b0;
            o_avs_readdata <= i_avs_read ? nxt_rdata : 32'h00000000;
            o_avs_response <= nxt_err ? 2'h2 : 2'h0;
        end
        else
        begin
            o_avs_waitrequest <= 1'b1;
            o_avs_response <= 2'h0;
        end
    end
endmodule

// >>> verification/ppmc_monitor.sv
`include "ppmc_defines.vh"
module ppmc_monitor (
    input wire i_ref_clk,
    input wire i_arst_n,
    input wire [7:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire i_standby_pin_input,
    input wire i_ovlo_below,
    input wire [2:0] i_chg_substate,
    input wire [3:0] i_cfg_pin_resistor,
    input wire [3:0] i_cfg_pin_bias,
    input wire o_avs_waitrequest,
    input wire [1:0] o_avs_response,
    input wire o_converter_en,
    input wire o_charge_en,
    input wire o_reverse_en,
    input wire [1:0] o_battery_path_switch,
    input wire [1:0] o_sys_target,
    input wire o_vin_reg_fixed_5v1,
    input wire [2:0] o_power_state
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_arst_n);
    a_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("request not answered in one cycle");
    a_bus_one_cycle: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_unmapped_err: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        && i_avs_address > 8'h1C |=> o_avs_response == 2'h2)
        else $error("unmapped access without error response");
    a_ov_batt_only: assert property ((!i_ovlo_below)[*6]
        |-> o_battery_path_switch == `PPMC_SW_ON && !o_charge_en)
        else $error("overvoltage input left switch off");
    a_standby_conv_off: assert property (i_standby_pin_input[*6] |-> !o_converter_en
        && o_battery_path_switch == `PPMC_SW_ON)
        else $error("standby pin did not stop converter");
    a_rev_switch_on: assert property (o_vin_reg_fixed_5v1
        |-> o_reverse_en && o_battery_path_switch == `PPMC_SW_ON)
        else $error("reverse regulation with switch not on");
    a_nochg_path: assert property (o_power_state == `PPMC_PS_NOCHG |-> o_converter_en
        && !o_charge_en && o_sys_target != `PPMC_SYS_NONE
        && o_battery_path_switch inside {`PPMC_SW_OFF, `PPMC_SW_SUPPL})
        else $error("no-charge state with wrong path");
    a_chg_sub_path: assert property (o_charge_en && $past(i_chg_substate) < 3'h4
        && $past(i_chg_substate) == $past(i_chg_substate, 2)
        && $past(i_chg_substate) == $past(i_chg_substate, 3)
        |-> o_battery_path_switch == ($past(i_chg_substate) < 3'h2 ?
        `PPMC_SW_LINEAR : `PPMC_SW_ON))
        else $error("charging sub-state with wrong switch");
    a_held_no_chg: assert property (o_charge_en
        |-> !((|i_cfg_pin_resistor) && (|i_cfg_pin_bias)))
        else $error("charging while strap hold");
endmodule
bind ppmc_power_path ppmc_monitor u_mon (.*);

// >>> verification/ppmc_host_model.sv
module ppmc_host_model (
    input wire i_ref_clk,
    input wire i_waitrequest,
    input wire [31:0] i_readdata,
    input wire [1:0] i_response,
    output logic [7:0] o_address = 8'h00,
    output logic o_read = 1'b0,
    output logic o_write = 1'b0,
    output logic [31:0] o_writedata = 32'h0,
    output logic [3:0] o_byteenable = 4'hF
);
    timeunit 1ns;
    timeprecision 1ps;
    // one word transfer, held until waitrequest is seen low or 50 cycles pass
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic [1:0] r, output logic to);
        int n;
        @(posedge i_ref_clk);
        o_address <= a;
        o_writedata <= d;
        o_read <= !wr;
        o_write <= wr;
        to = 1'b1;
        for (n = 0; n < 50 && to; n++)
        begin
            @(posedge i_ref_clk);
            if (i_waitrequest === 1'b0)
            begin
                q = i_readdata;
                r = i_response;
                to = 1'b0;
            end
        end
        o_read <= 1'b0;
        o_write <= 1'b0;
    endtask
endmodule

// >>> verification/tb_power_path_mode_control.sv
`include "ppmc_defines.vh"
module tb_power_path_mode_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 0, i_arst_n = 0, i_standby_pin_input = 0, i_uvlo_above = 0;
    logic i_ovlo_below = 1, i_adaptive_input_current_loop = 0, i_iin_below_30ma = 0;
    logic i_sys_at_supplement = 0;
    logic [2:0] i_chg_substate = 0;
    logic [3:0] i_cfg_pin_resistor = 4'hF, i_cfg_pin_bias = 4'h0;
    logic [7:0] i_charger_detail_sm = 0;
    logic i_chg_good_sm = 1;
    logic [6:0] i_dflt_input_limit = 0, i_dflt_charge_current = 0;
    logic [5:0] i_dflt_topoff = 0, i_dflt_term_voltage = 0;
    wire [7:0] i_avs_address;
    wire i_avs_read, i_avs_write, o_avs_waitrequest, o_converter_en, o_charge_en;
    wire o_reverse_en, o_vin_reg_fixed_5v1, o_irq;
    wire [31:0] i_avs_writedata, o_avs_readdata;
    wire [3:0] i_avs_byteenable;
    wire [1:0] o_avs_response, o_battery_path_switch, o_sys_target;
    wire [4:0] o_vin_reg_target;
    wire [2:0] o_rev_ilim, o_power_state;
    wire [6:0] o_input_limit, o_charge_current;
    wire [5:0] o_topoff, o_term_voltage;
    int fail_count = 0, samples_checked = 0, seed = 85, i;
    logic [31:0] q, w;
    logic [1:0] r;

    ppmc_power_path uut (.*);
    ppmc_host_model host (.i_ref_clk(i_ref_clk), .i_waitrequest(o_avs_waitrequest),
        .i_readdata(o_avs_readdata), .i_response(o_avs_response), .o_address(i_avs_address),
        .o_read(i_avs_read), .o_write(i_avs_write), .o_writedata(i_avs_writedata),
        .o_byteenable(i_avs_byteenable));

    initial
    begin
        forever #2 i_ref_clk = ~i_ref_clk;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic to;
        host.xfer(wr, a, d, q, r, to);
        if (to)
        begin
            fail_count++;
            $display("BAD t=%0t bus timeout", $time);
            stop_test;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        bus(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask
    task automatic settle;
        repeat (8) @(posedge i_ref_clk);
    endtask
    task automatic path(input logic cv, input logic [1:0] sw);
        chk({o_converter_en, o_battery_path_switch}, {cv, sw});
    endtask
    function automatic logic [1:0] sw_exp(input logic [2:0] s);
        return s < 3'h2 ? `PPMC_SW_LINEAR : (s < 3'h4 ? `PPMC_SW_ON : `PPMC_SW_OFF);
    endfunction

    initial
    begin
        w = $random(seed);
        {i_dflt_input_limit, i_dflt_topoff, i_dflt_charge_current,
            i_dflt_term_voltage} <= w[25:0];
        w = $random(seed);
        {i_charger_detail_sm, i_chg_good_sm} <= w[8:0];
        repeat (5) @(posedge i_ref_clk);
        i_arst_n <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        rd(`PPMC_ADDR_MODE, 32'h5, 32'hF);
        rd(`PPMC_ADDR_CTRL, 32'h0, 32'h3);
        rd(`PPMC_ADDR_DEFAULTS, {2'h0, i_dflt_term_voltage, 1'h0, i_dflt_charge_current, 2'h0,
            i_dflt_topoff, 1'h0, i_dflt_input_limit}, 32'hFFFFFFFF);
        rd(8'h20, 32'h0, 32'hFFFFFFFF);
        chk(r, 2'h2);
        rd(`PPMC_ADDR_STATUS, 32'h100, 32'h707);
        bus(1'b1, `PPMC_ADDR_IRQ_STAT, 32'h1);
        i_uvlo_above <= 1'b1;
        settle;
        rd(`PPMC_ADDR_STATUS, 32'h7, 32'h7);
        rd(`PPMC_ADDR_IRQ_STAT, 32'h1, 32'h1);
        chk(o_irq, 1'b1);
        bus(1'b1, `PPMC_ADDR_IRQ_MASK, 32'h1);
        bus(1'b1, `PPMC_ADDR_IRQ_STAT, 32'h1);
        chk(o_irq, 1'b0);
        i_ovlo_below <= 1'b0;
        settle;
        rd(`PPMC_ADDR_STATUS, 32'h4, 32'h7);
        rd(`PPMC_ADDR_IRQ_STAT, 32'h1, 32'h1);
        chk(o_irq, 1'b0);
        path(1'b0, `PPMC_SW_ON);
        i_ovlo_below <= 1'b1;
        i_uvlo_above <= 1'b0;
        i_adaptive_input_current_loop <= 1'b1;
        settle;
        rd(`PPMC_ADDR_STATUS, 32'h7, 32'h7);
        bus(1'b1, `PPMC_ADDR_IRQ_STAT, 32'h1);
        bus(1'b1, `PPMC_ADDR_IRQ_MASK, 32'h0);
        i_iin_below_30ma <= 1'b1;
        settle;
        rd(`PPMC_ADDR_STATUS, 32'h0, 32'h7);
        chk(o_irq, 1'b1);
        {i_adaptive_input_current_loop, i_iin_below_30ma, i_uvlo_above} <= 3'h1;
        settle;
        bus(1'b1, `PPMC_ADDR_MODE, `PPMC_MODE_OFF);
        settle;
        path(1'b0, `PPMC_SW_ON);
        bus(1'b1, `PPMC_ADDR_MODE, `PPMC_MODE_NOCHG);
        settle;
        path(1'b1, `PPMC_SW_OFF);
        chk({o_charge_en, o_sys_target}, {1'b0, `PPMC_SYS_BATTREG});
        i_sys_at_supplement <= 1'b1;
        settle;
        chk({o_battery_path_switch, o_sys_target}, {`PPMC_SW_SUPPL, `PPMC_SYS_SUPPL});
        i_sys_at_supplement <= 1'b0;
        bus(1'b1, `PPMC_ADDR_MODE, `PPMC_MODE_CHG);
        settle;
        chk({o_charge_en, o_battery_path_switch}, {1'b0, `PPMC_SW_OFF});
        bus(1'b1, `PPMC_ADDR_CTRL, 32'h2);
        for (i = 0; i < 8; i++)
        begin
            i_chg_substate <= i[2:0];
            settle;
            chk(o_battery_path_switch, sw_exp(i[2:0]));
            if (i < 2 || i > 3)
                chk(o_sys_target, `PPMC_SYS_BATTREG);
            if (i == 2)
                chk(o_charge_en, 1'b1);
        end
        bus(1'b1, `PPMC_ADDR_CTRL, 32'h3);
        settle;
        path(1'b0, `PPMC_SW_ON);
        bus(1'b1, `PPMC_ADDR_CTRL, 32'h2);
        i_standby_pin_input <= 1'b1;
        settle;
        path(1'b0, `PPMC_SW_ON);
        i_standby_pin_input <= 1'b0;
        w = $random(seed);
        bus(1'b1, `PPMC_ADDR_SETTINGS, {27'h0, w[4:0]});
        settle;
        chk(o_vin_reg_target, w[4:0]);
        bus(1'b1, `PPMC_ADDR_MODE, `PPMC_MODE_REV);
        i_ovlo_below <= 1'b0;
        for (i = 7; i >= 0; i--)
        begin
            bus(1'b1, `PPMC_ADDR_SETTINGS, {21'h0, i[2:0], 8'h0});
            settle;
            chk({o_reverse_en, o_vin_reg_fixed_5v1, o_rev_ilim}, {2'h3, i[2:0]});
            chk(o_battery_path_switch, `PPMC_SW_ON);
        end
        i_ovlo_below <= 1'b1;
        w = $random(seed) & 32'h3F7F3F7F;
        bus(1'b1, `PPMC_ADDR_DEFAULTS, w);
        settle;
        chk({o_term_voltage, o_charge_current, o_topoff, o_input_limit},
            {w[29:24], w[22:16], w[13:8], w[6:0]});
        rd(`PPMC_ADDR_CHG, {i_chg_good_sm, i_charger_detail_sm}, 32'h1FF);
        i_arst_n <= 1'b0;
        {i_cfg_pin_resistor, i_cfg_pin_bias} <= 8'h1E;
        repeat (3) @(posedge i_ref_clk);
        i_arst_n <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        rd(`PPMC_ADDR_CHG, {1'b0, `PPMC_DTLS_HELD}, 32'h1FF);
        bus(1'b1, `PPMC_ADDR_CTRL, 32'h2);
        settle;
        path(1'b1, `PPMC_SW_OFF);
        chk(o_charge_en, 1'b0);
        stop_test;
    end
endmodule
